// ### card_chk.sv
`timescale 1ns/1ns
`default_nettype none
module card_chk #(
  parameter int HALF_CYCLES = card_pkg::LINK_HALF_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic link_rst,
  input  wire logic link_clk,
  input  wire logic host_io_o,
  input  wire logic host_io_oe,
  input  wire logic card_io_o,
  input  wire logic card_io_oe,
  input  wire logic io_level
);
  logic [15:0] run_q;
  logic [8:0]  bits_q;
  logic [8:0]  pulses_q;
  logic [3:0]  since_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  // Counters for clock level length, frame bits, processing pulses and line events.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      run_q    <= 16'h0000;
      bits_q   <= 9'h000;
      pulses_q <= 9'h000;
      since_q  <= 4'h0;
    end else begin
      run_q    <= $changed(link_clk) ? 16'h0000 : run_q + 16'h0001;
      bits_q   <= $rose(link_rst) ? 9'h000 : bits_q + 9'(($rose(link_clk) && link_rst));
      pulses_q <= $fell(link_rst) ? 9'h000 : pulses_q + 9'(($rose(link_clk) && !link_rst));
      since_q  <= ($fell(link_clk) || $changed(link_rst)) ? 4'h0 :
                  since_q + 4'((since_q != 4'hF));
    end
  end

  a_clk_half_len: assert property ($changed(link_clk) |-> run_q >= 16'(HALF_CYCLES - 1))
    else $error("link clock level shorter than the half period");
  a_pulse_count: assert property ($rose(link_rst) |->
    pulses_q inside {9'd0, 9'd2, 9'd8, 9'd9, 9'd16, 9'd103, 9'd203})
    else $error("unexpected number of processing pulses");
  a_frame_len: assert property ($fell(link_rst) |-> (bits_q == 9'd24 || bits_q == 9'd1))
    else $error("command frame is not 24 bits long");
  a_done_release: assert property ($fell(card_io_oe) |-> since_q <= 4'd5)
    else $error("card released the data line without a clock fall or reset line edge");
  a_card_quiet_shift: assert property (link_rst [*6] |-> !card_io_oe)
    else $error("card drives the data line while the host shifts");
  a_host_off_read: assert property (!link_rst |-> !host_io_oe)
    else $error("host drives the data line while reading");
  a_host_data_setup: assert property ($changed(host_io_oe) |-> !link_clk && link_rst)
    else $error("host data changed while the link clock was high");
  a_rst_clk_low: assert property ($changed(link_rst) |-> !link_clk)
    else $error("reset line changed while the link clock was high");
  a_card_pull_low: assert property (card_io_oe |-> !card_io_o && !io_level)
    else $error("card enabled the data line without pulling it low");
  a_host_pull_low: assert property (host_io_oe |-> !host_io_o && !io_level)
    else $error("host enabled the data line without pulling it low");

  // The line goes low at the 103rd pulse, so a full erase and write shows at the next frame.
  c_erase_write: cover property ($rose(link_rst) && pulses_q == 9'd203);
  c_verify_done: cover property ($rose(card_io_oe) && !link_rst && pulses_q == 9'd2);
  c_full_frame: cover property ($fell(link_rst) && bits_q == 9'd24);
endmodule : card_chk
`default_nettype wire

// ### card_device.sv
`timescale 1ns/1ns
`default_nettype none
module card_device #(
  parameter logic [7:0] FACTORY_CODE_LO = 8'hA5,  // Arbitrary value.
  parameter logic [7:0] FACTORY_CODE_HI = 8'h3C   // Arbitrary value.
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  card_link_if.card       link,
  output var  logic       o_verified,
  output var  logic       o_write_enabled,
  output var  logic       o_locked,
  output var  logic [3:0] o_attempts
);
  import card_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_PROC  = 2'b11,
    ST_READ  = 2'b10
  } dev_state_e;

  dev_state_e  state_q;
  logic        clk_q;
  logic        rst_q;
  logic [23:0] shift_q;
  logic [4:0]  bits_q;
  logic [5:0]  cmd_q;
  logic [9:0]  addr_q;
  logic [7:0]  data_q;
  logic [7:0]  pulses_q;
  logic [3:0]  bit_q;
  logic        por_q;
  logic        atr_q;
  logic        read_seen_q;
  logic        done_q;
  logic        perm_q;
  logic        ctr_perm_q;
  logic        verified_q;
  logic        armed_q;
  logic        first_ok_q;
  logic        locked_q;
  logic        wr_en_q;
  logic [3:0]  attempts_q;
  logic        oe_q;
  logic [7:0]  mem_q [MEM_DEPTH];
  logic        prot_q [MEM_DEPTH];

  wire logic       clk_rise;
  wire logic       clk_fall;
  wire logic       rst_rise;
  wire logic       rst_fall;
  wire logic [5:0] cmd_w;
  wire logic [9:0] addr_w;
  wire logic [7:0] data_w;
  wire logic       full_w;
  wire logic       is_read_w;
  wire logic       is_prog_w;
  wire logic       is_wr_w;
  wire logic [7:0] pulse_next_w;
  wire logic       step1_w;
  wire logic       step2_w;
  wire logic [7:0] cur_w;
  wire logic [7:0] wr_only_w;
  wire logic [7:0] ctr_new_w;
  wire logic       cleared_w;
  wire logic       masked_w;
  wire logic [7:0] rd_byte_w;
  wire logic       rd_bit_w;
  wire logic [3:0] last_w;

  // Link lines are synchronous inputs; one stage gives edge detection.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      clk_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      clk_q <= link.link_clk;
      rst_q <= link.link_rst;
    end
  end

  // Edges and decode of the shifted command frame.
  assign clk_rise  = link.link_clk && !clk_q;
  assign clk_fall  = !link.link_clk && clk_q;
  assign rst_rise  = link.link_rst && !rst_q;
  assign rst_fall  = !link.link_rst && rst_q;
  assign cmd_w     = shift_q[5:0];
  assign addr_w    = {shift_q[FLD_A9], shift_q[FLD_A8], shift_q[FLD_ADDR_LSB +: 8]};
  assign data_w    = shift_q[FLD_DATA_LSB +: 8];
  assign full_w    = (bits_q == CMD_BITS);
  assign is_read_w = full_w && (cmd_w == CMD_READ8 || cmd_w == CMD_READ9);
  assign is_prog_w = full_w && (cmd_w == CMD_WRITE || cmd_w == CMD_WRITE_PROT ||
                                cmd_w == CMD_PROT_CMP || cmd_w == CMD_COUNTER ||
                                cmd_w == CMD_VERIFY);

  // Programming steps counted in link clock pulses.
  assign is_wr_w      = (cmd_q == CMD_WRITE) || (cmd_q == CMD_WRITE_PROT);
  assign pulse_next_w = pulses_q + 8'h01;
  assign step1_w      = (state_q == ST_PROC) && clk_rise &&
                        (pulse_next_w == ((cmd_q == CMD_VERIFY) ? PULSES_VERIFY : PULSES_WRITE));
  assign step2_w      = (state_q == ST_PROC) && clk_rise && (pulse_next_w == PULSES_ERASE_WRITE) &&
                        (is_wr_w || cmd_q == CMD_COUNTER);
  assign cur_w        = mem_q[addr_q];
  assign wr_only_w    = (data_q == BYTE_ERASED) ? BYTE_ERASED : (cur_w & data_q);
  assign ctr_new_w    = !verified_q ? (cur_w & data_q) :
                        (step2_w ? data_q : wr_only_w);
  assign cleared_w    = (cur_w & ~ctr_new_w) != 8'h00;

  // Read path: code bytes masked until verified, ninth bit is the protect bit.
  assign masked_w  = (addr_q == ADDR_CODE_LO || addr_q == ADDR_CODE_HI) && !verified_q;
  assign rd_byte_w = masked_w ? BYTE_MASKED : cur_w;
  assign rd_bit_w  = (bit_q == READ9_LAST) ? prot_q[addr_q] : rd_byte_w[bit_q[2:0]];
  assign last_w    = (cmd_q == CMD_READ9) ? READ9_LAST : READ8_LAST;

  // Command sequencer; a rising reset line aborts whatever runs and opens a new frame.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q  <= ST_IDLE;
      shift_q  <= 24'h00_0000;
      bits_q   <= 5'h00;
      cmd_q    <= CMD_READ8;
      addr_q   <= 10'h000;
      data_q   <= 8'h00;
      pulses_q <= 8'h00;
      bit_q    <= 4'h0;
    end else if (rst_rise) begin
      state_q <= ST_SHIFT;
      bits_q  <= 5'h00;
    end else begin
      case (state_q)
        ST_SHIFT: begin
          if (rst_fall) begin
            cmd_q    <= atr_q ? CMD_READ8 : cmd_w;
            addr_q   <= atr_q ? 10'h000 : addr_w;
            data_q   <= data_w;
            pulses_q <= 8'h00;
            bit_q    <= 4'h0;
            state_q  <= (atr_q || is_read_w) ? ST_READ : (is_prog_w ? ST_PROC : ST_IDLE);
          end else if (clk_rise && !por_q && !full_w) begin
            shift_q <= {link.io_level, shift_q[23:1]};
            bits_q  <= bits_q + 5'h01;
          end
        end
        ST_READ: begin
          if (clk_fall && bit_q == last_w) begin
            bit_q  <= 4'h0;
            addr_q <= addr_q + 10'h001;
          end else if (clk_fall) begin
            bit_q <= bit_q + 4'h1;
          end
        end
        ST_PROC: begin
          if (clk_rise && pulses_q != 8'hFF) begin
            pulses_q <= pulse_next_w;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Power-on state, read history, access permission latched at decode and completion flag.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      por_q       <= 1'b1;
      atr_q       <= 1'b0;
      read_seen_q <= 1'b0;
      perm_q      <= 1'b0;
      ctr_perm_q  <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      if (state_q == ST_SHIFT && clk_rise && por_q) begin
        por_q <= 1'b0;
        atr_q <= 1'b1;
      end
      if (state_q == ST_SHIFT && rst_fall) begin
        atr_q      <= 1'b0;
        read_seen_q <= read_seen_q || (is_read_w && !atr_q);
        perm_q     <= verified_q && read_seen_q && !locked_q && (prot_q[addr_w] == PROT_OPEN) &&
                      (addr_w != ADDR_COUNTER);
        ctr_perm_q <= read_seen_q && !locked_q && (addr_w == ADDR_COUNTER);
      end
      if (rst_rise) begin
        done_q <= 1'b0;
      end else if (step1_w) begin
        done_q <= 1'b1;
      end
    end
  end

  // Nonvolatile array with protect bits, filled with factory contents at power-on.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i]  <= BYTE_ERASED;
        prot_q[i] <= PROT_OPEN;
      end
      mem_q[ADDR_CODE_LO] <= FACTORY_CODE_LO;
      mem_q[ADDR_CODE_HI] <= FACTORY_CODE_HI;
    end else begin
      if (is_wr_w && perm_q && step1_w) begin
        mem_q[addr_q] <= wr_only_w;
      end
      if (is_wr_w && perm_q && step2_w) begin
        mem_q[addr_q] <= data_q;
      end
      if (cmd_q == CMD_WRITE_PROT && perm_q && step1_w) begin
        prot_q[addr_q] <= PROT_SET;
      end
      if (cmd_q == CMD_PROT_CMP && perm_q && step1_w && cur_w == data_q) begin
        prot_q[addr_q] <= PROT_SET;
      end
      if (cmd_q == CMD_COUNTER && ctr_perm_q && (step1_w || (step2_w && verified_q))) begin
        mem_q[addr_q] <= ctr_new_w;
      end
    end
  end

  // Code gate: a cleared counter bit arms one attempt, low byte then high byte.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      verified_q <= 1'b0;
      armed_q    <= 1'b0;
      first_ok_q <= 1'b0;
    end else begin
      if (cmd_q == CMD_COUNTER && ctr_perm_q && step1_w && cleared_w) begin
        armed_q <= 1'b1;
      end
      if (cmd_q == CMD_VERIFY && step1_w && armed_q && !locked_q) begin
        if (addr_q == ADDR_CODE_LO) begin
          first_ok_q <= (data_q == cur_w);
        end else if (addr_q == ADDR_CODE_HI) begin
          verified_q <= first_ok_q && (data_q == cur_w);
          armed_q    <= 1'b0;
          first_ok_q <= 1'b0;
        end
      end
    end
  end

  // Registered status and the open-drain data driver.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      locked_q   <= 1'b0;
      wr_en_q    <= 1'b0;
      attempts_q <= 4'h0;
      oe_q       <= 1'b0;
    end else begin
      locked_q   <= (mem_q[ADDR_COUNTER] == 8'h00);
      wr_en_q    <= verified_q && read_seen_q && !locked_q;
      attempts_q <= 4'($countones(mem_q[ADDR_COUNTER]));
      oe_q       <= done_q || (state_q == ST_READ && !rd_bit_w);
    end
  end

  assign link.card_io_o   = 1'b0;
  assign link.card_io_oe  = oe_q;
  assign o_verified       = verified_q;
  assign o_write_enabled  = wr_en_q;
  assign o_locked         = locked_q;
  assign o_attempts       = attempts_q;
endmodule : card_device
`default_nettype wire

// ### card_host.sv
`timescale 1ns/1ns
`default_nettype none
module card_host #(
  parameter int HALF_CYCLES = card_pkg::LINK_HALF_CYCLES
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  card_link_if.host       link,
  input  wire logic       i_start,
  input  wire logic [5:0] i_control,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_data,
  input  wire logic [8:0] i_pulses,
  output var  logic       o_ready,
  output var  logic       o_done,
  output var  logic [8:0] o_rx_data,
  output var  logic       o_io_level
);
  import card_pkg::*;

  localparam int DIV_W = $clog2(HALF_CYCLES + 1);

  typedef enum logic [2:0] {
    H_WAKE   = 3'b000,
    H_IDLE   = 3'b001,
    H_RST_UP = 3'b011,
    H_SHIFT  = 3'b010,
    H_RST_DN = 3'b110,
    H_PULSE  = 3'b111
  } host_state_e;

  host_state_e      state_q;
  logic [DIV_W-1:0] div_q;
  logic [4:0]       step_q;
  logic [23:0]      word_q;
  logic [8:0]       cnt_q;
  logic             rst_q;
  logic             clk_q;
  logic             oe_q;
  logic             ready_q;
  logic             done_q;
  logic [8:0]       rx_q;
  logic             lvl_q;
  wire logic        tick_w;

  // Half-period divider that paces every link line change.
  assign tick_w = (div_q == DIV_W'(HALF_CYCLES - 1));
  always_ff @(posedge i_clock) begin
    if (i_reset || tick_w) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Link sequencer: power-on release, frame shift, then processing or read pulses.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= H_WAKE;
      step_q  <= 5'h00;
      word_q  <= 24'h00_0000;
      cnt_q   <= 9'h000;
      rst_q   <= 1'b0;
      clk_q   <= 1'b0;
      oe_q    <= 1'b0;
      ready_q <= 1'b0;
      done_q  <= 1'b0;
      rx_q    <= 9'h000;
      lvl_q   <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (state_q == H_IDLE && i_start) begin
        word_q  <= {i_data, i_addr[7:0], i_addr[9], i_addr[8], i_control};
        cnt_q   <= i_pulses;
        rx_q    <= 9'h000;
        ready_q <= 1'b0;
        state_q <= H_RST_UP;
      end else if (tick_w) begin
        case (state_q)
          H_WAKE: begin
            step_q <= step_q + 5'h01;
            if (step_q == 5'h00) begin
              rst_q <= 1'b1;
            end else if (step_q == 5'h01) begin
              clk_q <= 1'b1;
            end else if (step_q == 5'h02) begin
              clk_q <= 1'b0;
            end else begin
              rst_q   <= 1'b0;
              ready_q <= 1'b1;
              state_q <= H_IDLE;
            end
          end
          H_RST_UP: begin
            rst_q   <= 1'b1;
            oe_q    <= !word_q[0];
            step_q  <= 5'h00;
            state_q <= H_SHIFT;
          end
          H_SHIFT: begin
            if (!clk_q) begin
              clk_q <= 1'b1;
            end else if (step_q == CMD_BITS - 5'h01) begin
              clk_q   <= 1'b0;
              oe_q    <= 1'b0;
              state_q <= H_RST_DN;
            end else begin
              clk_q  <= 1'b0;
              word_q <= {1'b0, word_q[23:1]};
              oe_q   <= !word_q[1];
              step_q <= step_q + 5'h01;
            end
          end
          H_RST_DN: begin
            rst_q   <= 1'b0;
            state_q <= H_PULSE;
          end
          H_PULSE: begin
            if (clk_q) begin
              clk_q <= 1'b0;
              rx_q  <= {link.io_level, rx_q[8:1]};
              cnt_q <= cnt_q - 9'h001;
            end else if (cnt_q != 9'h000) begin
              clk_q <= 1'b1;
            end else begin
              lvl_q   <= link.io_level;
              done_q  <= 1'b1;
              ready_q <= 1'b1;
              state_q <= H_IDLE;
            end
          end
          default: state_q <= H_IDLE;
        endcase
      end
    end
  end

  assign link.link_rst   = rst_q;
  assign link.link_clk   = clk_q;
  assign link.host_io_o  = 1'b0;
  assign link.host_io_oe = oe_q;
  assign o_ready         = ready_q;
  assign o_done          = done_q;
  assign o_rx_data       = rx_q;
  assign o_io_level      = lvl_q;
endmodule : card_host
`default_nettype wire

// ### card_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface card_link_if;
  logic link_rst;
  logic link_clk;
  logic host_io_o;
  logic host_io_oe;
  logic card_io_o;
  logic card_io_oe;
  wire logic io_level;

  // Open-drain data line: either end pulls it low, otherwise it floats high.
  assign io_level = !(host_io_oe && !host_io_o) && !(card_io_oe && !card_io_o);

  modport host (output link_rst, link_clk, host_io_o, host_io_oe, input io_level);
  modport card (input link_rst, link_clk, io_level, output card_io_o, card_io_oe);
endinterface : card_link_if
`default_nettype wire

// ### card_pkg.sv
package card_pkg;
  // System clock and the link clock ceiling; the half period keeps the link below the ceiling.
  localparam int CLOCK_HZ         = 20_000_000;
  localparam int LINK_MAX_HZ      = 20_000;
  localparam int LINK_HALF_CYCLES = CLOCK_HZ / (2 * LINK_MAX_HZ) + 1;

  // Command frame: 24 bits, least significant first.
  localparam logic [4:0] CMD_BITS     = 5'h18;
  localparam int         FLD_A8       = 6;
  localparam int         FLD_A9       = 7;
  localparam int         FLD_ADDR_LSB = 8;
  localparam int         FLD_DATA_LSB = 16;

  // Control words, bit k holds control bit k of the frame.
  localparam logic [5:0] CMD_READ8      = 6'h0E;
  localparam logic [5:0] CMD_READ9      = 6'h0C;
  localparam logic [5:0] CMD_WRITE      = 6'h33;
  localparam logic [5:0] CMD_WRITE_PROT = 6'h31;
  localparam logic [5:0] CMD_PROT_CMP   = 6'h30;
  localparam logic [5:0] CMD_COUNTER    = 6'h32;
  localparam logic [5:0] CMD_VERIFY     = 6'h0D;

  // Processing pulse counts: 103 write or erase only, 203 erase then write, 2 for a compare.
  localparam logic [7:0] PULSES_WRITE       = 8'h67;
  localparam logic [7:0] PULSES_ERASE_WRITE = 8'hCB;
  localparam logic [7:0] PULSES_VERIFY      = 8'h02;

  // Memory map and byte values.
  localparam int         MEM_DEPTH    = 1024;
  localparam int         ATTEMPTS_MAX = 8;
  localparam logic [9:0] ADDR_COUNTER = 10'h3FD;
  localparam logic [9:0] ADDR_CODE_LO = 10'h3FE;
  localparam logic [9:0] ADDR_CODE_HI = 10'h3FF;
  localparam logic [7:0] BYTE_ERASED  = 8'hFF;
  localparam logic [7:0] BYTE_MASKED  = 8'h00;
  localparam logic       PROT_OPEN    = 1'b1;
  localparam logic       PROT_SET     = 1'b0;
  localparam logic [3:0] READ8_LAST   = 4'h7;
  localparam logic [3:0] READ9_LAST   = 4'h8;
endpackage : card_pkg

// ### testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import card_pkg::*;
  localparam int         HALF    = 4;
  localparam logic [7:0] CODE_LO = 8'hA5;  // Arbitrary code loaded at power-on.
  localparam logic [7:0] CODE_HI = 8'h3C;  // Arbitrary code loaded at power-on.
  logic       i_clock, i_reset, i_start, o_ready, o_done, o_io_level;
  logic       o_verified, o_write_enabled, o_locked;
  logic [5:0] i_control;
  logic [9:0] i_addr, a;
  logic [7:0] i_data, d;
  logic [8:0] i_pulses, o_rx_data;
  logic [3:0] o_attempts;
  logic [7:0] mem [0:1023];
  logic       prot [0:1023];
  int         n_fail, compares, cycles, seed;

  card_link_if link ();
  card_host #(.HALF_CYCLES(HALF)) card_host_i (.i_clock(i_clock), .i_reset(i_reset),
    .link(link), .i_start(i_start), .i_control(i_control), .i_addr(i_addr), .i_data(i_data),
    .i_pulses(i_pulses), .o_ready(o_ready), .o_done(o_done), .o_rx_data(o_rx_data),
    .o_io_level(o_io_level));
  card_device #(.FACTORY_CODE_LO(CODE_LO), .FACTORY_CODE_HI(CODE_HI)) card_device_i (
    .i_clock(i_clock), .i_reset(i_reset), .link(link),
    .o_verified(o_verified), .o_write_enabled(o_write_enabled), .o_locked(o_locked),
    .o_attempts(o_attempts));
  card_chk #(.HALF_CYCLES(HALF)) card_chk_i (.i_clock(i_clock), .i_reset(i_reset),
    .link_rst(link.link_rst), .link_clk(link.link_clk), .host_io_o(link.host_io_o),
    .host_io_oe(link.host_io_oe), .card_io_o(link.card_io_o), .card_io_oe(link.card_io_oe),
    .io_level(link.io_level));

  // Clock generator.
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Hang guard.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Expected byte after a programming run of the given length.
  function automatic logic [7:0] prog(input logic [7:0] old, input logic [7:0] dt,
                                      input logic [8:0] p);
    if (p == 9'd203) return dt;
    return (dt == BYTE_ERASED) ? BYTE_ERASED : (old & dt);
  endfunction : prog

  // Power-on reset of both ends and the reference contents.
  task automatic por();
    i_reset <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int k = 0; k < 1024; k++) begin
      mem[k] = BYTE_ERASED;
      prot[k] = PROT_OPEN;
    end
    mem[ADDR_CODE_LO] = CODE_LO;
    mem[ADDR_CODE_HI] = CODE_HI;
  endtask : por

  // One host command, waiting for the done pulse and the flags to settle.
  task automatic cmd(input logic [5:0] c, input logic [9:0] ad, input logic [7:0] dt,
                     input logic [8:0] p);
    do @(posedge i_clock); while (o_ready !== 1'b1);
    i_start   <= 1'b1;
    i_control <= c;
    i_addr    <= ad;
    i_data    <= dt;
    i_pulses  <= p;
    @(posedge i_clock);
    i_start <= 1'b0;
    do @(posedge i_clock); while (o_done !== 1'b1);
    repeat (3) @(posedge i_clock);
  endtask : cmd

  // Programming command, then a nine-bit read back compared with the reference.
  task automatic wr(input logic [5:0] c, input logic [9:0] ad, input logic [7:0] dt,
                    input logic [8:0] p, input logic en);
    cmd(c, ad, dt, p);
    check(9'(o_io_level), 9'h000, "completion level");
    check(9'(link.io_level), 9'h000, "line held low");
    if (en && prot[ad]) begin
      if (c == CMD_WRITE_PROT || (c == CMD_PROT_CMP && dt == mem[ad])) begin
        prot[ad] = PROT_SET;
      end
      if (c != CMD_PROT_CMP) mem[ad] = prog(mem[ad], dt, p);
    end
    cmd(CMD_READ9, ad, 8'h00, 9'd9);
    check(o_rx_data, {prot[ad], mem[ad]}, "stored byte");
  endtask : wr

  task automatic verify(input logic [7:0] lo, input logic [7:0] hi);
    cmd(CMD_VERIFY, ADDR_CODE_LO, lo, 9'(PULSES_VERIFY));
    cmd(CMD_VERIFY, ADDR_CODE_HI, hi, 9'(PULSES_VERIFY));
  endtask : verify

  // Main sequence.
  initial begin
    seed = 64631;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    i_start = 1'b0;
    i_control = 6'h00;
    i_addr = 10'h000;
    i_data = 8'h00;
    i_pulses = 9'h000;
    por();
    wr(CMD_WRITE, 10'h005, 8'h12, 9'd203, 1'b0);
    check(9'(o_attempts), 9'h008, "attempts");
    cmd(CMD_READ8, ADDR_CODE_LO, 8'h00, 9'd16);
    check(o_rx_data, 9'h000, "masked code");
    wr(CMD_COUNTER, ADDR_COUNTER, 8'hFE, 9'd103, 1'b1);
    verify(8'h00, CODE_HI);
    check({o_verified, 4'h0, o_attempts}, 9'h007, "failed entry");
    wr(CMD_COUNTER, ADDR_COUNTER, 8'hFC, 9'd103, 1'b1);
    verify(CODE_LO, CODE_HI);
    check({o_verified, o_write_enabled, 3'h0, o_attempts}, 9'h186, "good entry");
    wr(CMD_COUNTER, ADDR_COUNTER, 8'hFF, 9'd203, 1'b1);
    check(9'(o_attempts), 9'h008, "restored attempts");
    wr(CMD_WRITE, ADDR_CODE_LO, 8'h5A, 9'd203, 1'b1);
    wr(CMD_WRITE, ADDR_COUNTER, 8'h00, 9'd203, 1'b0);
    for (int k = 0; k < 5; k++) begin
      a = 10'(16 + {$random(seed)} % 1000);
      d = 8'($random(seed));
      wr(CMD_WRITE, a, d, 9'd203, 1'b1);
      d = (k == 0) ? 8'hFF : 8'($random(seed));
      wr(CMD_WRITE, a, d, 9'd103, 1'b1);
    end
    wr(CMD_WRITE_PROT, 10'h009, 8'h5A, 9'd203, 1'b1);
    wr(CMD_WRITE, 10'h009, 8'h00, 9'd203, 1'b1);
    wr(CMD_PROT_CMP, 10'h00A, 8'h11, 9'd103, 1'b1);
    wr(CMD_PROT_CMP, 10'h00A, 8'hFF, 9'd103, 1'b1);
    por();
    cmd(CMD_READ8, 10'h000, 8'h00, 9'd8);
    check(9'(o_verified), 9'h000, "verified after power-on");
    wr(CMD_COUNTER, ADDR_COUNTER, 8'h00, 9'd103, 1'b1);
    verify(CODE_LO, CODE_HI);
    check({o_verified, o_locked, 3'h0, o_attempts}, 9'h080, "locked");
    wr(CMD_WRITE, 10'h020, 8'h00, 9'd203, 1'b0);
    close_out();
  end
endmodule : testbench
`default_nettype wire
